// *** include/fwps_pkg.sv ***
package fwps_pkg;
  // Timing base
  localparam int CLOCK_MHZ = 125;
  localparam int STATUS_WRITE_TIME_US = 10;
  localparam int STATUS_WRITE_CYCLES = STATUS_WRITE_TIME_US * CLOCK_MHZ;
  localparam int POWER_UP_WRITE_DELAY_US = 1000;
  localparam int ADDR_W = 22;
  localparam int SR_TIMER_W = 16;
  // Instruction codes
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_STATUS_LOW = 8'h05;
  localparam logic [7:0] OP_READ_STATUS_HIGH = 8'h35;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
  localparam logic [7:0] OP_BLOCK64_ERASE = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE = 8'hc7;
  localparam logic [7:0] OP_SECURITY_ERASE = 8'h44;
  localparam logic [7:0] OP_SECURITY_PROGRAM = 8'h42;
  localparam logic [7:0] OP_POWER_DOWN = 8'hb9;
  localparam logic [7:0] OP_RELEASE_DOWN = 8'hab;
  localparam logic [7:0] OP_QPI_ON = 8'h38;
  localparam logic [7:0] OP_QPI_OFF = 8'hff;
  localparam logic [7:0] OP_RESET_ARM = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  // Frame lengths in whole bytes
  localparam logic [2:0] BYTES_OPCODE = 3'd1;
  localparam logic [2:0] BYTES_ONE_DATA = 3'd2;
  localparam logic [2:0] BYTES_TWO_DATA = 3'd3;
  localparam logic [2:0] BYTES_ADDR = 3'd4;
  // Erase and program unit masks
  localparam logic [ADDR_W-1:0] UNIT_PAGE = 22'h0000ff;
  localparam logic [ADDR_W-1:0] UNIT_SECTOR = 22'h000fff;
  localparam logic [ADDR_W-1:0] UNIT_BLOCK32 = 22'h007fff;
  localparam logic [ADDR_W-1:0] UNIT_BLOCK64 = 22'h00ffff;
  // Protect-size decoding
  localparam logic [2:0] SIZE_NONE = 3'h0;
  localparam logic [2:0] SIZE_ALL = 3'h7;
  localparam logic [2:0] SIZE_SMALL_CAP = 3'h4;
  localparam logic [4:0] EXP_SMALL_BASE = 5'h0b;
  localparam logic [4:0] EXP_BLK_BASE = 5'h0f;
  // Field positions inside the written bytes
  localparam int SR1_BP_LSB = 2;
  localparam int SR1_TOP_BOTTOM = 5;
  localparam int SR1_SMALL_UNIT = 6;
  localparam int SR1_GUARD_LOW = 7;
  localparam int SR2_GUARD_HIGH = 0;
  localparam int SR2_QUAD = 1;
  localparam int SR2_LOCK = 2;
  localparam int SR2_INVERT = 4;
  localparam int SR2_DRV_LSB = 5;
  typedef enum logic [1:0] {
    DRIVE_FULL, DRIVE_THREE_QUARTER, DRIVE_HALF, DRIVE_QUARTER
  } fwps_drive_t;
  typedef enum logic [2:0] {
    ARR_PAGE_PROGRAM, ARR_SECTOR_ERASE, ARR_BLOCK32_ERASE,
    ARR_BLOCK64_ERASE, ARR_CHIP_ERASE, ARR_SECURITY_ERASE,
    ARR_SECURITY_PROGRAM
  } fwps_array_op_t;
  typedef struct packed {
    fwps_array_op_t op;
    logic [ADDR_W-1:0] addr;
  } fwps_array_cmd_t;
  typedef struct packed {
    fwps_drive_t drv;
    logic invert_protection;
    logic security_lock_otp;
    logic quad_lines_enable;
    logic status_guard_mode_high;
    logic status_guard_mode_low;
    logic small_unit_select;
    logic top_bottom_select;
    logic [2:0] protect_size;
  } fwps_nv_t;
  typedef struct packed {
    logic op_failed;
    fwps_drive_t drv;
    logic invert_protection;
    logic reserved;
    logic security_lock_otp;
    logic quad_lines_enable;
    logic status_guard_mode_high;
    logic status_guard_mode_low;
    logic small_unit_select;
    logic top_bottom_select;
    logic [2:0] protect_size;
    logic write_latch;
    logic op_in_progress;
  } fwps_status_t;
  localparam fwps_nv_t NV_RESET = 12'h000;
  localparam fwps_status_t STATUS_RESET = 16'h0000;
endpackage : fwps_pkg

// *** logic/fwps_flash_guard.sv ***
// Function
// - While supply is low, stay in reset and recognise no instruction.
// - After supply rises, refuse all write-type instructions for a delay.
// - Power-up leaves the write latch at zero.
// - Program, erase and status write need the write latch set.
// - Completion of program, erase or status write clears the latch.
// - Latch bit S1 set by enable, cleared by disable and write ops.
// - In power-down only the release instruction is obeyed.
// - Busy bit S0 high during operations; only status reads accepted.
// - Size bits S4-2 select refused region; zero protects nothing while S12 is clear.
// - Top/bottom bit picks which end the region grows from.
// - Granularity bit selects 4KB sectors or 64KB blocks.
// - Complement bit S12 inverts the selected protected region.
// - Guard mode 00: pin ignored, status writable with latch set.
// - Guard mode 01: low protect pin locks status, high allows.
// - Guard mode 10 locks status until power cycle, which clears it.
// - Guard mode 11 locks status permanently.
// - Protect pin gates status writes only in standard or dual mode.
// - Drive field 00..11 gives 100, 75, 50, 25 percent.
// - Failure flag set on failed operation, not on protection refusal.
// - Failure flag clears at power-up, software reset, write enable.
// - Every status bit starts at zero.
// - Security lock bit S10 is one-time settable, never cleared.
// - Quad enable S9; a status write in quad mode cannot clear it.
module fwps_flash_guard #(
  parameter int POWER_UP_WRITE_DELAY_CYCLES =
    fwps_pkg::POWER_UP_WRITE_DELAY_US * fwps_pkg::CLOCK_MHZ
) (
  // System
  input wire logic CLOCK_IN,
  input wire logic NRST_IN,
  // Supply monitor
  input wire logic VCC_OK_IN,
  // Serial link
  input wire logic SCLK_IN,
  input wire logic CS_N_IN,
  input wire logic SDI_IN,
  input wire logic WP_N_IN,
  output logic SDO_OUT,
  output logic SDO_OE_OUT,
  // Array engine
  input wire logic ARRAY_DONE_IN,
  input wire logic ARRAY_FAIL_IN,
  output logic ARRAY_BUSY_OUT,
  output fwps_pkg::fwps_array_cmd_t ARRAY_CMD_OUT,
  // Status view
  output fwps_pkg::fwps_status_t STATUS_OUT,
  output fwps_pkg::fwps_drive_t DRIVE_STRENGTH_OUT,
  output logic POWERED_DOWN_OUT,
  output logic QPI_MODE_OUT
);
  import fwps_pkg::*;

  typedef enum logic [2:0] {
    ST_SUPPLY_LOW, ST_IDLE, ST_SR_WRITE, ST_ARRAY, ST_POWER_DOWN
  } fwps_state_t;

  // Link-side capture
  logic spi_rst_n;
  logic fresh;
  logic [2:0] bit_idx;
  logic [2:0] byte_cnt;
  logic [7:0] spi_op;
  logic [23:0] spi_data;
  logic [16:0] view_meta;
  logic [16:0] view_sync;
  logic [7:0] read_byte;
  // Core side
  fwps_state_t state;
  logic cs_meta, cs_sync, cs_prev, frame_end;
  logic wp_meta, wp_sync, vcc_meta, vcc_sync;
  logic [31:0] puw_cnt;
  logic [SR_TIMER_W-1:0] sr_timer;
  logic write_latch, err, qpi, rst_arm, answer_ok;
  logic [16:0] view_hold;
  fwps_nv_t nv, next_nv;
  fwps_status_t status_q;
  // Decoded strobes
  logic full, one, write_ok, guard_ok, pin_active;
  logic cmd_we, cmd_wd, cmd_srw, cmd_pd, cmd_rel;
  logic cmd_qpi_on, cmd_qpi_off, cmd_arm, cmd_reset;
  logic arr_req, arr_blocked, cmd_arr, cmd_arr_refused;
  logic sr_done, arr_done;
  fwps_array_op_t arr_op;
  logic [ADDR_W-1:0] arr_mask, arr_addr;
  logic [7:0] sr1_byte, sr2_byte;

  // Region test: prefix or suffix of the array, optionally inverted
  function automatic logic region_hit(input logic [ADDR_W-1:0] addr,
                                      input fwps_nv_t s);
    logic [4:0] ex;
    logic [ADDR_W-1:0] mask;
    logic hit;
    ex = EXP_BLK_BASE;
    mask = '0;
    hit = 1'b0;
    if (s.protect_size == SIZE_NONE) begin
      hit = 1'b0;
    end else if (s.protect_size == SIZE_ALL) begin
      hit = 1'b1;
    end else begin
      if (s.small_unit_select) begin
        ex = EXP_SMALL_BASE + ((s.protect_size > SIZE_SMALL_CAP) ?
             {2'b00, SIZE_SMALL_CAP} : {2'b00, s.protect_size});
      end else begin
        ex = EXP_BLK_BASE + {2'b00, s.protect_size};
      end
      mask = ~(({{(ADDR_W-1){1'b0}}, 1'b1} << ex) - 22'h000001);
      if (s.top_bottom_select) begin
        hit = ((addr & mask) == 22'h000000);
      end else begin
        hit = ((addr & mask) == mask);
      end
    end
    return hit ^ s.invert_protection;
  endfunction : region_hit

  // Link reset: chip select high or system reset re-arms the frame
  assign spi_rst_n = NRST_IN & ~CS_N_IN;

  // First edge of a frame restarts the counters
  always_ff @(posedge SCLK_IN or negedge spi_rst_n) begin
    if (!spi_rst_n) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  // Shift in opcode and up to three bytes; held after the frame ends
  always_ff @(posedge SCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      bit_idx <= 3'h0;
      byte_cnt <= 3'h0;
      spi_op <= 8'h00;
      spi_data <= 24'h000000;
    end else begin
      bit_idx <= (fresh ? 3'h0 : bit_idx) + 3'h1;
      if (fresh) begin
        byte_cnt <= 3'h0;
        spi_op <= {spi_op[6:0], SDI_IN};
      end else begin
        if (bit_idx == 3'h7 && byte_cnt != BYTES_ADDR) begin
          byte_cnt <= byte_cnt + 3'h1;
        end
        if (byte_cnt == 3'h0) begin
          spi_op <= {spi_op[6:0], SDI_IN};
        end else if (byte_cnt != BYTES_ADDR) begin
          spi_data <= {spi_data[22:0], SDI_IN};
        end
      end
    end
  end

  // Status view into the link clock; the held word is still by the time
  // the answer byte reads it, so all bits come from one core update
  always_ff @(posedge SCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      view_meta <= 17'h00000;
      view_sync <= 17'h00000;
    end else begin
      view_meta <= view_hold;
      view_sync <= view_meta;
    end
  end

  // Status read answer, valid even while busy
  assign read_byte = (spi_op == OP_READ_STATUS_HIGH) ?
                     view_sync[15:8] : view_sync[7:0];
  always_ff @(negedge SCLK_IN or negedge spi_rst_n) begin
    if (!spi_rst_n) begin
      SDO_OUT <= 1'b0;
      SDO_OE_OUT <= 1'b0;
    end else if (!fresh && byte_cnt != 3'h0 && view_sync[16] &&
                 (spi_op == OP_READ_STATUS_LOW ||
                  spi_op == OP_READ_STATUS_HIGH)) begin
      SDO_OE_OUT <= 1'b1;
      SDO_OUT <= read_byte[3'h7 - bit_idx];
    end else begin
      SDO_OE_OUT <= 1'b0;
      SDO_OUT <= 1'b0;
    end
  end

  // Pin synchronisers; frame end is chip select going high
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_prev <= 1'b1;
      wp_meta <= 1'b0;
      wp_sync <= 1'b0;
      vcc_meta <= 1'b0;
      vcc_sync <= 1'b0;
    end else begin
      cs_meta <= CS_N_IN;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
      wp_meta <= WP_N_IN;
      wp_sync <= wp_meta;
      vcc_meta <= VCC_OK_IN;
      vcc_sync <= vcc_meta;
    end
  end
  assign frame_end = cs_sync & ~cs_prev;

  // Word frozen while a frame runs; a read shows the status at frame start
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      view_hold <= 17'h00000;
    end else if (cs_sync) begin
      view_hold <= {answer_ok, status_q};
    end
  end

  // Instruction decode; captured link words are still while select is high
  always_comb begin
    full = frame_end && state == ST_IDLE && bit_idx == 3'h0;
    one = byte_cnt == BYTES_OPCODE;
    write_ok = write_latch && puw_cnt == 32'h0;
    pin_active = !qpi && !nv.quad_lines_enable;
    case ({nv.status_guard_mode_high, nv.status_guard_mode_low})
      2'b00: guard_ok = 1'b1;
      2'b01: guard_ok = !pin_active || wp_sync;
      default: guard_ok = 1'b0;
    endcase
    cmd_we = full && one && spi_op == OP_WRITE_ENABLE &&
             puw_cnt == 32'h0;
    cmd_wd = full && one && spi_op == OP_WRITE_DISABLE;
    cmd_srw = full && spi_op == OP_WRITE_STATUS && write_ok &&
              guard_ok && (byte_cnt == BYTES_ONE_DATA ||
              byte_cnt == BYTES_TWO_DATA);
    cmd_pd = full && one && spi_op == OP_POWER_DOWN;
    cmd_rel = frame_end && state == ST_POWER_DOWN && bit_idx == 3'h0 &&
              one && spi_op == OP_RELEASE_DOWN;
    cmd_qpi_on = full && one && spi_op == OP_QPI_ON &&
                 nv.quad_lines_enable;
    cmd_qpi_off = full && one && spi_op == OP_QPI_OFF;
    cmd_arm = full && one && spi_op == OP_RESET_ARM;
    cmd_reset = full && one && spi_op == OP_RESET && rst_arm;
    arr_addr = spi_data[ADDR_W-1:0];
    arr_req = 1'b0;
    arr_op = ARR_PAGE_PROGRAM;
    arr_mask = UNIT_PAGE;
    case (spi_op)
      OP_PAGE_PROGRAM: begin
        arr_req = byte_cnt == BYTES_ADDR;
      end
      OP_SECTOR_ERASE: begin
        arr_req = byte_cnt == BYTES_ADDR;
        arr_op = ARR_SECTOR_ERASE;
        arr_mask = UNIT_SECTOR;
      end
      OP_BLOCK32_ERASE: begin
        arr_req = byte_cnt == BYTES_ADDR;
        arr_op = ARR_BLOCK32_ERASE;
        arr_mask = UNIT_BLOCK32;
      end
      OP_BLOCK64_ERASE: begin
        arr_req = byte_cnt == BYTES_ADDR;
        arr_op = ARR_BLOCK64_ERASE;
        arr_mask = UNIT_BLOCK64;
      end
      OP_CHIP_ERASE: begin
        arr_req = one;
        arr_op = ARR_CHIP_ERASE;
      end
      OP_SECURITY_ERASE: begin
        arr_req = byte_cnt == BYTES_ADDR;
        arr_op = ARR_SECURITY_ERASE;
      end
      OP_SECURITY_PROGRAM: begin
        arr_req = byte_cnt == BYTES_ADDR;
        arr_op = ARR_SECURITY_PROGRAM;
      end
      default: begin
        arr_req = 1'b0;
      end
    endcase
    arr_req = arr_req && full && write_ok;
    // Aligned units against a prefix/suffix region: both ends suffice
    case (arr_op)
      ARR_CHIP_ERASE: arr_blocked = nv.invert_protection ?
        (nv.protect_size != SIZE_ALL) : (nv.protect_size != SIZE_NONE);
      ARR_SECURITY_ERASE, ARR_SECURITY_PROGRAM:
        arr_blocked = nv.security_lock_otp;
      default: arr_blocked = region_hit(arr_addr & ~arr_mask, nv) ||
                             region_hit(arr_addr | arr_mask, nv);
    endcase
    cmd_arr = arr_req && !arr_blocked;
    cmd_arr_refused = arr_req && arr_blocked;
  end

  // Status write payload; one data byte touches only the low byte
  always_comb begin
    sr1_byte = (byte_cnt == BYTES_ONE_DATA) ? spi_data[7:0] :
               spi_data[15:8];
    sr2_byte = spi_data[7:0];
    next_nv = nv;
    next_nv.protect_size = sr1_byte[SR1_BP_LSB+:3];
    next_nv.top_bottom_select = sr1_byte[SR1_TOP_BOTTOM];
    next_nv.small_unit_select = sr1_byte[SR1_SMALL_UNIT];
    next_nv.status_guard_mode_low = sr1_byte[SR1_GUARD_LOW];
    if (byte_cnt == BYTES_TWO_DATA) begin
      next_nv.status_guard_mode_high = sr2_byte[SR2_GUARD_HIGH];
      next_nv.quad_lines_enable = qpi ? 1'b1 : sr2_byte[SR2_QUAD];
      next_nv.security_lock_otp = nv.security_lock_otp |
                                  sr2_byte[SR2_LOCK];
      next_nv.invert_protection = sr2_byte[SR2_INVERT];
      next_nv.drv = fwps_drive_t'(sr2_byte[SR2_DRV_LSB+:2]);
    end
  end

  assign sr_done = state == ST_SR_WRITE && sr_timer == '0;
  assign arr_done = state == ST_ARRAY && ARRAY_DONE_IN;

  // Operating state; supply loss overrides everything
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      state <= ST_SUPPLY_LOW;
    end else if (!vcc_sync) begin
      state <= ST_SUPPLY_LOW;
    end else begin
      case (state)
        ST_SUPPLY_LOW: state <= ST_IDLE;
        ST_IDLE: begin
          if (cmd_srw) begin
            state <= ST_SR_WRITE;
          end else if (cmd_arr) begin
            state <= ST_ARRAY;
          end else if (cmd_pd) begin
            state <= ST_POWER_DOWN;
          end
        end
        ST_SR_WRITE: if (sr_done) state <= ST_IDLE;
        ST_ARRAY: if (ARRAY_DONE_IN) state <= ST_IDLE;
        ST_POWER_DOWN: if (cmd_rel) state <= ST_IDLE;
        default: state <= ST_SUPPLY_LOW;
      endcase
    end
  end

  // Write delay after the supply comes good
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      puw_cnt <= 32'(POWER_UP_WRITE_DELAY_CYCLES);
    end else if (!vcc_sync) begin
      puw_cnt <= 32'(POWER_UP_WRITE_DELAY_CYCLES);
    end else if (puw_cnt != 32'h0) begin
      puw_cnt <= puw_cnt - 32'h1;
    end
  end

  // Status write busy period
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      sr_timer <= '0;
    end else if (cmd_srw) begin
      sr_timer <= SR_TIMER_W'(STATUS_WRITE_CYCLES - 1);
    end else if (sr_timer != '0) begin
      sr_timer <= sr_timer - SR_TIMER_W'(1);
    end
  end

  // Write latch
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      write_latch <= 1'b0;
    end else if (!vcc_sync) begin
      write_latch <= 1'b0;
    end else if (cmd_we) begin
      write_latch <= 1'b1;
    end else if (cmd_wd || cmd_arr_refused || cmd_reset) begin
      write_latch <= 1'b0;
    end else if (sr_done || arr_done) begin
      write_latch <= 1'b0;
    end
  end

  // Failure flag; supply loss clears first, a failing completion wins over the other clears
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      err <= 1'b0;
    end else if (!vcc_sync) begin
      err <= 1'b0;
    end else if (arr_done && ARRAY_FAIL_IN) begin
      err <= 1'b1;
    end else if (cmd_we || cmd_reset) begin
      err <= 1'b0;
    end
  end

  // Non-volatile fields: only system reset stands for factory state
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      nv <= NV_RESET;
    end else if (!vcc_sync) begin
      if (nv.status_guard_mode_high && !nv.status_guard_mode_low) begin
        nv.status_guard_mode_high <= 1'b0;
      end
    end else if (cmd_srw) begin
      nv <= next_nv;
    end
  end

  // Quad-command mode and two-step software reset
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      qpi <= 1'b0;
      rst_arm <= 1'b0;
    end else if (!vcc_sync) begin
      qpi <= 1'b0;
      rst_arm <= 1'b0;
    end else if (full) begin
      rst_arm <= cmd_arm;
      if (cmd_qpi_on) begin
        qpi <= 1'b1;
      end else if (cmd_qpi_off || cmd_reset) begin
        qpi <= 1'b0;
      end
    end
  end

  // Array command register
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      ARRAY_CMD_OUT <= '0;
      ARRAY_BUSY_OUT <= 1'b0;
    end else begin
      ARRAY_BUSY_OUT <= vcc_sync && (cmd_arr ||
                        (state == ST_ARRAY && !ARRAY_DONE_IN));
      if (cmd_arr) begin
        ARRAY_CMD_OUT <= '{op: arr_op, addr: arr_addr};
      end
    end
  end

  // Registered status view and side outputs
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      status_q <= STATUS_RESET;
      answer_ok <= 1'b0;
      DRIVE_STRENGTH_OUT <= DRIVE_FULL;
      POWERED_DOWN_OUT <= 1'b0;
      QPI_MODE_OUT <= 1'b0;
    end else begin
      status_q.op_failed <= err;
      status_q.drv <= nv.drv;
      status_q.invert_protection <= nv.invert_protection;
      status_q.reserved <= 1'b0;
      status_q.security_lock_otp <= nv.security_lock_otp;
      status_q.quad_lines_enable <= nv.quad_lines_enable;
      status_q.status_guard_mode_high <= nv.status_guard_mode_high;
      status_q.status_guard_mode_low <= nv.status_guard_mode_low;
      status_q.small_unit_select <= nv.small_unit_select;
      status_q.top_bottom_select <= nv.top_bottom_select;
      status_q.protect_size <= nv.protect_size;
      status_q.write_latch <= write_latch;
      status_q.op_in_progress <= state == ST_SR_WRITE ||
                                 state == ST_ARRAY;
      answer_ok <= vcc_sync && state != ST_SUPPLY_LOW &&
                   state != ST_POWER_DOWN;
      DRIVE_STRENGTH_OUT <= nv.drv;
      POWERED_DOWN_OUT <= state == ST_POWER_DOWN;
      QPI_MODE_OUT <= qpi;
    end
  end
  assign STATUS_OUT = status_q;

endmodule : fwps_flash_guard

// *** sim/fwps_flash_guard_checker.sv ***
module fwps_flash_guard_checker (
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic NRST_IN,
  // Watched ports
  input wire logic VCC_OK_IN,
  input wire logic ARRAY_DONE_IN,
  input wire logic ARRAY_FAIL_IN,
  input wire logic ARRAY_BUSY_OUT,
  input wire fwps_pkg::fwps_status_t STATUS_OUT,
  input wire fwps_pkg::fwps_drive_t DRIVE_STRENGTH_OUT
);
  timeunit 1ns;
  timeprecision 100ps;
  import fwps_pkg::*;
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!NRST_IN);
  // Engine finishing a running operation
  sequence s_done;
    ARRAY_BUSY_OUT && ARRAY_DONE_IN;
  endsequence
  sequence s_failed;
    s_done ##0 ARRAY_FAIL_IN;
  endsequence
  a_busy_drops: assert property (s_done |=> !ARRAY_BUSY_OUT)
    else $error("busy held after done");
  a_latch_cleared: assert property (
    s_done |-> ##[1:3] !STATUS_OUT.write_latch)
    else $error("latch kept after operation");
  a_fail_flagged: assert property (
    s_failed |-> ##[1:3] STATUS_OUT.op_failed)
    else $error("failure not flagged");
  a_busy_shown: assert property (
    $rose(ARRAY_BUSY_OUT) |-> ##[0:2] STATUS_OUT.op_in_progress)
    else $error("busy bit not shown");
  a_start_needs_latch: assert property (
    $rose(ARRAY_BUSY_OUT) |-> $past(STATUS_OUT.write_latch))
    else $error("operation without latch");
  a_drive_shown: assert property (
    !$stable(DRIVE_STRENGTH_OUT)
      |-> ##[0:2] (STATUS_OUT.drv == DRIVE_STRENGTH_OUT))
    else $error("drive field mismatch");
  a_otp_guard_holds: assert property (
    STATUS_OUT.status_guard_mode_high && STATUS_OUT.status_guard_mode_low
      |=> STATUS_OUT.status_guard_mode_high &&
          STATUS_OUT.status_guard_mode_low)
    else $error("permanent guard changed");
  a_supply_low_reset: assert property (
    !VCC_OK_IN [*8] |-> !STATUS_OUT.write_latch && !ARRAY_BUSY_OUT)
    else $error("active while supply low");
endmodule : fwps_flash_guard_checker

bind fwps_flash_guard fwps_flash_guard_checker u_chk (
  .CLOCK_IN(CLOCK_IN), .NRST_IN(NRST_IN), .VCC_OK_IN(VCC_OK_IN),
  .ARRAY_DONE_IN(ARRAY_DONE_IN), .ARRAY_FAIL_IN(ARRAY_FAIL_IN),
  .ARRAY_BUSY_OUT(ARRAY_BUSY_OUT), .STATUS_OUT(STATUS_OUT),
  .DRIVE_STRENGTH_OUT(DRIVE_STRENGTH_OUT));

// *** sim/fwps_spi_host.sv ***
module fwps_spi_host (
  // Serial link toward the guard
  output logic sclk_out,
  output logic cs_n_out,
  output logic sdi_out,
  input wire logic sdo_in,
  input wire logic sdo_oe_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // Set when the guard drove the data line during the last frame
  logic oe_seen = 1'h0;
  // Mode 0 idle: clock parked low, deselected
  initial begin
    sclk_out = 1'h0;
    cs_n_out = 1'h1;
    sdi_out = 1'h0;
  end
  // Whole bytes msb first, 32 ns bits; clock runs only inside frames
  task automatic xfer(input logic [31:0] d, input int n,
                      output logic [7:0] rd);
    cs_n_out = 1'h0;
    oe_seen = 1'h0;
    for (int i = 0; i < 8 * n; i++) begin
      sdi_out = d[31 - i];
      #16 sclk_out = 1'h1;
      rd = {rd[6:0], sdo_in};
      oe_seen = oe_seen | sdo_oe_in;
      #16 sclk_out = 1'h0;
    end
    #16 cs_n_out = 1'h1;
    // Released line shows the inverse, never a stale bit
    sdi_out = ~sdi_out;
    #120;
  endtask : xfer
endmodule : fwps_spi_host

// *** sim/test_flash_write_protect_status.sv ***
module test_flash_write_protect_status;
  timeunit 1ns;
  timeprecision 100ps;
  import fwps_pkg::*;
  // Short power-up delay keeps the run brief
  localparam int PUW = 100;
  localparam logic [31:0] WREN = {OP_WRITE_ENABLE, 24'h0};
  logic clk = 1'h0, nrst = 1'h0, vcc_ok = 1'h1, wp_n = 1'h1;
  logic done = 1'h0, fail = 1'h0;
  logic sclk, cs_n, sdi, sdo, oe, busy, pdn, qpi_mode;
  fwps_array_cmd_t acmd;
  fwps_status_t st;
  fwps_drive_t drv;
  logic [7:0] rd;
  logic [15:0] cur;
  int mismatches = 0, checks = 0;
  // Core clock, 8 ns
  always #4 clk = ~clk;
  fwps_flash_guard #(.POWER_UP_WRITE_DELAY_CYCLES(PUW)) u_dut (
    .CLOCK_IN(clk), .NRST_IN(nrst), .VCC_OK_IN(vcc_ok), .SCLK_IN(sclk),
    .CS_N_IN(cs_n), .SDI_IN(sdi), .WP_N_IN(wp_n), .SDO_OUT(sdo),
    .SDO_OE_OUT(oe), .ARRAY_DONE_IN(done), .ARRAY_FAIL_IN(fail),
    .ARRAY_BUSY_OUT(busy), .ARRAY_CMD_OUT(acmd), .STATUS_OUT(st),
    .DRIVE_STRENGTH_OUT(drv), .POWERED_DOWN_OUT(pdn), .QPI_MODE_OUT(qpi_mode));
  fwps_spi_host u_host (.sclk_out(sclk), .cs_n_out(cs_n),
    .sdi_out(sdi), .sdo_in(sdo), .sdo_oe_in(oe));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Frame, then room for the take and the status lag
  task automatic cmd(input logic [31:0] d, input int n);
    u_host.xfer(d, n, rd);
    repeat (8) @(negedge clk);
  endtask : cmd
  // Enable and write both bytes, waiting out the write time
  task automatic wrsr(input logic [7:0] lo, input logic [7:0] hi);
    cmd(WREN, 1);
    cmd({OP_WRITE_STATUS, lo, hi, 8'h0}, 3);
    repeat (STATUS_WRITE_CYCLES + 20) @(negedge clk);
  endtask : wrsr
  // Program a page; the engine finishes accepted ones
  task automatic prog(input logic [21:0] a, input bit ok, input bit f);
    cmd(WREN, 1);
    cmd({OP_PAGE_PROGRAM, 2'h0, a}, 4);
    check(busy, ok);
    check(st.op_in_progress, ok);
    if (ok) begin
      check(acmd, {ARR_PAGE_PROGRAM, a});
      done = 1'h1;
      fail = f;
      @(negedge clk);
      done = 1'h0;
      repeat (4) @(negedge clk);
    end
    check(st.op_failed, ok && f);
    check(st[1:0], 2'h0);
  endtask : prog
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict
  // Watchdog well beyond the expected run
  initial begin
    repeat (60000) @(negedge clk);
    mismatches++;
    print_verdict();
  end
  initial begin
    repeat (4) @(negedge clk);
    nrst = 1'h1;
    check(st, 16'h0);
    check(st.write_latch, 1'h0);
    cmd(WREN, 1);
    check(st.write_latch, 1'h0);
    repeat (PUW) @(negedge clk);
    cmd(WREN, 1);
    u_host.xfer({OP_READ_STATUS_LOW, 24'h0}, 2, rd);
    check(rd, 8'h02);
    check(u_host.oe_seen, 1'h1);
    cmd({OP_WRITE_DISABLE, 24'h0}, 1);
    cmd({OP_WRITE_STATUS, 8'h1c, 16'h0}, 2);
    check(st, 16'h0);
    // Pin low must not matter with guard mode 00
    wp_n = 1'h0;
    for (int i = 0; i < 4; i++) begin
      cur = {1'h0, i[1:0], 5'h0, 8'h04};
      wrsr(cur[7:0], cur[15:8]);
      check(st, cur);
      check(drv, i[1:0]);
    end
    prog(22'h3f0000, 0, 0);
    prog(22'h000000, 1, 1);
    cmd(WREN, 1);
    check(st.op_failed, 1'h0);
    wrsr(8'h24, 8'h60);
    prog(22'h000000, 0, 0);
    prog(22'h3f0000, 1, 0);
    wrsr(8'h44, 8'h60);
    prog(22'h3ff000, 0, 0);
    prog(22'h3fe000, 1, 0);
    wrsr(8'h24, 8'h70);
    prog(22'h3f0000, 0, 0);
    prog(22'h000000, 1, 0);
    wrsr(8'h80, 8'h60);
    wrsr(8'h84, 8'h60);
    check(st, 16'h6082);
    wp_n = 1'h1;
    wrsr(8'h04, 8'h61);
    check(st, 16'h6104);
    cmd(WREN, 1);
    cmd({OP_WRITE_STATUS, 8'h00, 8'h60, 8'h0}, 3);
    check(st, 16'h6106);
    vcc_ok = 1'h0;
    // Let the supply loss reach the held status word before reading
    repeat (8) @(negedge clk);
    u_host.xfer({OP_READ_STATUS_LOW, 24'h0}, 2, rd);
    check(rd, 8'h00);
    check(u_host.oe_seen, 1'h0);
    check(st, 16'h6004);
    vcc_ok = 1'h1;
    repeat (PUW + 10) @(negedge clk);
    cmd({OP_POWER_DOWN, 24'h0}, 1);
    check(pdn, 1'h1);
    cmd(WREN, 1);
    check(st.write_latch, 1'h0);
    cmd({OP_RELEASE_DOWN, 24'h0}, 1);
    check(pdn, 1'h0);
    // Quad enable and lock; quad mode keeps the enable and hides the pin
    wrsr(8'h04, 8'h66);
    cmd({OP_QPI_ON, 24'h0}, 1);
    check(qpi_mode, 1'h1);
    wrsr(8'h84, 8'h60);
    check(st, 16'h6684);
    wp_n = 1'h0;
    wrsr(8'h04, 8'h60);
    check(st, 16'h6604);
    check(st.security_lock_otp, 1'h1);
    wp_n = 1'h1;
    cmd({OP_QPI_OFF, 24'h0}, 1);
    check(qpi_mode, 1'h0);
    wrsr(8'h84, 8'h61);
    wrsr(8'h04, 8'h60);
    check(st, 16'h6586);
    print_verdict();
  end
endmodule : test_flash_write_protect_status
